// ---- src/hlb_pkg.sv ----
// constants, register map and types of the host and link boot loader
package hlb_pkg;
    localparam logic [7:0]  REG_PORT_DMA_CONTROL     = 8'h00;
    localparam logic [7:0]  REG_PORT_INTERNAL_INDEX  = 8'h04;
    localparam logic [7:0]  REG_PORT_INTERNAL_COUNT  = 8'h08;
    localparam logic [7:0]  REG_SYSTEM_CONFIGURATION = 8'h0c;
    localparam logic [7:0]  REG_LINK_CONTROL         = 8'h10;
    localparam logic [7:0]  REG_BOOT_STATUS          = 8'h14;
    localparam logic [7:0]  REG_PROGRAM_COUNTER      = 8'h18;

    localparam logic [31:0] PORT_DMA_CONTROL_RST     = 32'h0000_0161;
    localparam int          DMA_ENABLE_BIT           = 0;
    // fields sit so that the 0x161 reset value reads lsb first, 8-to-48, three column
    localparam int          WORD_ORDER_FLAG          = 1;
    localparam int          PACKING_CODE_LSB         = 6;
    localparam int          DATA_TYPE_BIT            = 5;
    localparam logic [2:0]  PACK_8_TO_48             = 3'h5;

    localparam logic [31:0] BOOT_INDEX_RST           = 32'h0004_0000;
    localparam logic [15:0] BOOT_COUNT_RST           = 16'h0100;
    localparam logic [31:0] BOOT_LAST_ADDR           = 32'h0004_00ff;
    localparam logic [31:0] PC_IDLE                  = 32'h0004_0004;
    localparam logic [31:0] PC_RESET_ROUTINE         = 32'h0004_0005;
    localparam logic [31:0] PC_WAKE_VECTOR           = 32'h0004_0050;

    localparam int          SYSTEM_CONFIGURATION_WIDTH16_BIT       = 0;
    localparam logic [31:0] SYSTEM_CONFIGURATION_RST = 32'h0000_0000;
    localparam logic [31:0] LINK_CONTROL_RST         = 32'h0000_0000;
    localparam int          LINK_WIDTH48_BIT         = 0;

    localparam int          WORD_BITS                = 48;
    localparam logic [3:0]  NIBS_PER_WORD            = 4'hc;

    typedef enum logic [3:0] {
        ST_SAMPLE = 4'b0001,
        ST_WAIT   = 4'b0010,
        ST_RUN    = 4'b0100,
        ST_OTHER  = 4'b1000
    } hlb_state_e;

    typedef enum logic [1:0] {
        MODE_NONE = 2'h0,
        MODE_HOST = 2'h1,
        MODE_LINK = 2'h2
    } hlb_mode_e;
endpackage : hlb_pkg

// ---- src/hlb_pack_if.sv ----
// pieces in, 48-bit words out, between the loader and its packer
`timescale 1ns/1ps
interface hlb_pack_if;
    logic        piece_valid;
    logic [15:0] piece_data;
    logic [2:0]  piece_nibs;
    logic        msb_first;
    logic        clear;
    logic        word_valid;
    logic [47:0] word_data;

    modport loader (output piece_valid, piece_data, piece_nibs, msb_first, clear,
                    input word_valid, word_data);
    modport packer (input piece_valid, piece_data, piece_nibs, msb_first, clear,
                    output word_valid, word_data);
endinterface : hlb_pack_if

// ---- src/hlb_packer.sv ----
// packs 4, 8 or 16-bit pieces into 48-bit instruction words
`timescale 1ns/1ps
module hlb_packer
    import hlb_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset,
    hlb_pack_if.packer pk
);
    logic [47:0] acc_q;
    logic [47:0] acc_d;
    logic [47:0] piece_w;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;

    always_comb begin
        unique case (pk.piece_nibs)
            3'h1:    piece_w = {44'h0, pk.piece_data[3:0]};
            3'h2:    piece_w = {40'h0, pk.piece_data[7:0]};
            default: piece_w = {32'h0, pk.piece_data};
        endcase
        cnt_d = cnt_q + {1'b0, pk.piece_nibs};
        // msb first shifts older nibbles up, lsb first places at the fill point
        if (pk.msb_first) begin
            acc_d = (acc_q << {pk.piece_nibs, 2'b00}) | piece_w;
        end else begin
            acc_d = acc_q | (piece_w << {cnt_q, 2'b00});
        end
    end

    always_ff @(posedge clk) begin
        if (reset || pk.clear) begin
            acc_q         <= 48'h0;
            cnt_q         <= 4'h0;
            pk.word_valid <= 1'b0;
            pk.word_data  <= 48'h0;
        end else begin
            pk.word_valid <= 1'b0;
            if (pk.piece_valid) begin
                if (cnt_d >= NIBS_PER_WORD) begin
                    pk.word_data  <= acc_d;
                    pk.word_valid <= 1'b1;
                    acc_q         <= 48'h0;
                    cnt_q         <= 4'h0;
                end else begin
                    acc_q <= acc_d;
                    cnt_q <= cnt_d;
                end
            end
        end
    end
endmodule : hlb_packer

// ---- src/hlb_boot_loader.sv ----
// boot sequencer for host and link power-up boot with wishbone registers
//
// Our own choices: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
// Contract
// R1 - ebsel low, lbsel low, bmsel high at reset selects host boot
// R2 - host boot: stay slave, wait passively, start no external access
// R3 - port dma control resets to 0x161: enable, lsb first, 8-to-48 packing
// R4 - host sends 8 or 16-bit pieces; device packs them into 48-bit words
// R5 - load 256 words at 0x40000..0x400ff, execute only after load completes
// R6 - host boot: index 0x40000, count 0x100 at reset, modifier one
// R7 - after reset release idle with program counter 0x40004, then init dma
// R8 - host arbitrates with bus request and chip select before writing
// R9 - after grant and ready host may change boot width via system config
// R10 - host writes buffer zero; slave dma moves words to memory
// R11 - count decrements per word; at zero stop, interrupt, vector 0x40050
// R12 - acknowledge line held high during reset by keeper
// R13 - return from interrupt at wake vector resumes at 0x40005
// R14 - ebsel low, lbsel high, bmsel high at reset selects link boot
// R15 - link boot uses channel 8, 4-bit data into link buffer zero
// R16 - source supplies link clock, at most the processor clock rate; code samples it in clk, so it must stay below half that rate
// R17 - each nibble captured on a falling edge of the link clock
// R18 - source sends each 48-bit word most significant nibble first
// R19 - link boot: count 0x100, index 0x40000 at reset, modifier one
// R20 - link boot overrides link control so buffer zero takes 48-bit words
// R21 - link buffer zero always carries boot data
// R22 - mode pins latched once after reset release, held until boot done
module hlb_boot_loader
    import hlb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        external_boot_select,
    input  wire logic        link_boot_select,
    input  wire logic        boot_memory_select,
    input  wire logic        host_bus_request,
    input  wire logic        host_chip_select,
    input  wire logic        host_write,
    input  wire logic        host_addr,
    input  wire logic [15:0] host_data,
    output logic             host_bus_grant,
    output logic             host_ready,
    output logic             ack_o,
    output logic             ack_oe,
    input  wire logic        link_clock,
    input  wire logic [3:0]  link_data,
    input  wire logic        rti,
    output logic             mem_we,
    output logic      [31:0] mem_addr,
    output logic      [47:0] mem_wdata,
    output logic             port_wakeup_interrupt,
    output logic      [31:0] pc,
    output logic      [1:0]  boot_mode
);
    hlb_state_e  state_q;
    logic [2:0]  pins_s1;
    logic [2:0]  pins_s2;
    logic [2:0]  host_s1;
    logic [2:0]  host_s2;
    logic        haddr_s1;
    logic        haddr_s2;
    logic [15:0] hdata_s1;
    logic [15:0] hdata_s2;
    logic        hwr_prev_q;
    logic        lclk_s1;
    logic        lclk_s2;
    logic        lclk_prev_q;
    logic [3:0]  ldata_s1;
    logic [3:0]  ldata_s2;
    logic [31:0] port_dma_control_q;
    logic [31:0] system_configuration_q;
    logic [31:0] link_control_q;
    logic [31:0] index_q;
    logic [15:0] count_q;
    logic        wb_req;
    logic        wb_wr;
    logic        host_wr_edge;
    logic        link_fall;
    logic        dma_on;
    logic [31:0] link_ctl_eff;
    hlb_pack_if  pk ();

    function automatic logic [31:0] wb_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) r[i*8 +: 8] = new_v[i*8 +: 8];
        end
        return r;
    endfunction : wb_merge

    function automatic logic wb_hit(input logic [7:0] adr, input logic [7:0] off);
        return adr[7:2] == off[7:2];
    endfunction : wb_hit

    // the boot, host and link pins cross into clk through two flops before any logic reads them
    always_ff @(posedge clk) begin
        pins_s1  <= {external_boot_select, link_boot_select, boot_memory_select};
        pins_s2  <= pins_s1;
        host_s1  <= {host_bus_request, host_chip_select, host_write};
        host_s2  <= host_s1;
        haddr_s1 <= host_addr;
        haddr_s2 <= haddr_s1;
        hdata_s1 <= host_data;
        hdata_s2 <= hdata_s1;
        lclk_s1  <= link_clock;
        lclk_s2  <= lclk_s1;
        ldata_s1 <= link_data;
        ldata_s2 <= ldata_s1;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            hwr_prev_q  <= 1'b0;
            lclk_prev_q <= 1'b0;
        end else begin
            hwr_prev_q  <= host_s2[0];
            lclk_prev_q <= lclk_s2;
        end
    end

    assign wb_req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr        = wb_req && wb_we_i;
    assign dma_on       = port_dma_control_q[DMA_ENABLE_BIT];
    assign host_wr_edge = host_s2[0] && !hwr_prev_q && host_bus_grant && host_ready;
    assign link_fall    = lclk_prev_q && !lclk_s2 && (boot_mode == MODE_LINK); // R17 R21
    // forced to 48-bit words while link boot is running
    assign link_ctl_eff = (boot_mode == MODE_LINK && state_q == ST_WAIT) ?
                          (link_control_q | (32'h1 << LINK_WIDTH48_BIT)) : link_control_q; // R20

    // mode latch: first clock after reset release, then frozen
    always_ff @(posedge clk) begin
        if (reset) begin
            state_q   <= ST_SAMPLE;
            boot_mode <= MODE_NONE;
        end else begin
            unique case (state_q)
                ST_SAMPLE: begin
                    if (pins_s2 == 3'b001) begin
                        boot_mode <= MODE_HOST; // R1 R22
                        state_q   <= ST_WAIT;
                    end else if (pins_s2 == 3'b011) begin
                        boot_mode <= MODE_LINK; // R14 R22
                        state_q   <= ST_WAIT;
                    end else begin
                        state_q <= ST_OTHER;
                    end
                end
                ST_WAIT: begin
                    if (mem_we && count_q == 16'h0) state_q <= ST_RUN; // R5
                end
                ST_RUN:   state_q <= ST_RUN;
                ST_OTHER: state_q <= ST_OTHER;
            endcase
        end
    end

    // host arbitration: only answers, never initiates an access
    always_ff @(posedge clk) begin
        if (reset) begin
            host_bus_grant <= 1'b0;
            host_ready     <= 1'b0;
            ack_o          <= 1'b1; // R12
            ack_oe         <= 1'b1; // R12
        end else begin
            host_bus_grant <= (boot_mode == MODE_HOST) && host_s2[2] && host_s2[1]; // R2 R8
            host_ready     <= (boot_mode == MODE_HOST) && host_s2[2] && host_s2[1]
                              && dma_on && state_q == ST_WAIT; // R9
            ack_o          <= 1'b1;
            ack_oe         <= 1'b1;
        end
    end

    // pieces to the packer: host order set by WORD_ORDER_FLAG (lsb first at reset), link msb first
    always_comb begin
        // partial words never survive outside the loading state
        pk.clear       = state_q != ST_WAIT;
        pk.piece_valid = 1'b0;
        pk.piece_data  = hdata_s2;
        pk.piece_nibs  = system_configuration_q[SYSTEM_CONFIGURATION_WIDTH16_BIT] ? 3'h4 : 3'h2; // R4
        pk.msb_first   = port_dma_control_q[WORD_ORDER_FLAG];
        if (boot_mode == MODE_LINK) begin
            pk.piece_data  = {12'h0, ldata_s2};
            pk.piece_nibs  = 3'h1; // R15
            pk.msb_first   = 1'b1; // R18
            pk.piece_valid = link_fall && dma_on && state_q == ST_WAIT;
        end else begin
            pk.piece_valid = host_wr_edge && !haddr_s2 && dma_on && state_q == ST_WAIT; // R10
        end
    end

    hlb_packer u_packer (
        .clk   (clk),
        .reset (reset),
        .pk    (pk)
    );

    // slave dma: one channel set serves channel 10 or channel 8 by mode
    always_ff @(posedge clk) begin
        if (reset) begin
            index_q   <= BOOT_INDEX_RST; // R6 R19
            count_q   <= BOOT_COUNT_RST; // R6 R19
            mem_we    <= 1'b0;
            mem_addr  <= 32'h0;
            mem_wdata <= 48'h0;
        end else begin
            mem_we <= 1'b0;
            if (pk.word_valid && state_q == ST_WAIT && count_q != 16'h0) begin
                mem_we    <= 1'b1;
                mem_addr  <= index_q; // R5
                mem_wdata <= pk.word_data;
                index_q   <= index_q + 32'h1;
                count_q   <= count_q - 16'h1; // R11
            end
        end
    end

    // program counter and wake-up interrupt
    always_ff @(posedge clk) begin
        if (reset) begin
            pc                    <= PC_IDLE; // R7
            port_wakeup_interrupt <= 1'b0;
        end else begin
            port_wakeup_interrupt <= 1'b0;
            if (state_q == ST_WAIT && mem_we && count_q == 16'h0) begin
                pc                    <= PC_WAKE_VECTOR; // R11
                port_wakeup_interrupt <= 1'b1; // R11
            end else if (rti && state_q == ST_RUN && pc == PC_WAKE_VECTOR) begin
                pc <= PC_RESET_ROUTINE; // R13
            end
        end
    end

    // register writes; host write to config wins over the bus in the same cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            port_dma_control_q     <= PORT_DMA_CONTROL_RST; // R3
            system_configuration_q <= SYSTEM_CONFIGURATION_RST;
            link_control_q         <= LINK_CONTROL_RST;
        end else begin
            if (wb_wr && wb_hit(wb_adr_i, REG_PORT_DMA_CONTROL))
                port_dma_control_q <= wb_merge(port_dma_control_q, wb_dat_i, wb_sel_i);
            if (wb_wr && wb_hit(wb_adr_i, REG_LINK_CONTROL))
                link_control_q <= wb_merge(link_control_q, wb_dat_i, wb_sel_i);
            if (host_wr_edge && haddr_s2)
                system_configuration_q <= {16'h0, hdata_s2}; // R9
            else if (wb_wr && wb_hit(wb_adr_i, REG_SYSTEM_CONFIGURATION))
                system_configuration_q <= wb_merge(system_configuration_q, wb_dat_i,
                                                   wb_sel_i);
        end
    end

    // one wait state; unmapped reads return zero and are still acknowledged
    always_ff @(posedge clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0;
            if (wb_req && !wb_we_i) begin
                unique case (wb_adr_i[7:2])
                    REG_PORT_DMA_CONTROL[7:2]:     wb_dat_o <= port_dma_control_q;
                    REG_PORT_INTERNAL_INDEX[7:2]:  wb_dat_o <= index_q;
                    REG_PORT_INTERNAL_COUNT[7:2]:  wb_dat_o <= {16'h0, count_q};
                    REG_SYSTEM_CONFIGURATION[7:2]: wb_dat_o <= system_configuration_q;
                    REG_LINK_CONTROL[7:2]:         wb_dat_o <= link_ctl_eff;
                    REG_BOOT_STATUS[7:2]:          wb_dat_o <= {24'h0, state_q, 2'h0, boot_mode};
                    REG_PROGRAM_COUNTER[7:2]:      wb_dat_o <= pc;
                    default:                       wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    property p_host_decode;
        state_q == ST_SAMPLE && pins_s2 == 3'b001 |=> boot_mode == MODE_HOST;
    endproperty
    a_host_decode: assert property (p_host_decode) else $error("host mode not taken"); // R1

    property p_link_decode;
        state_q == ST_SAMPLE && pins_s2 == 3'b011 |=> boot_mode == MODE_LINK;
    endproperty
    a_link_decode: assert property (p_link_decode) else $error("link mode not taken"); // R14

    property p_mode_hold;
        state_q != ST_SAMPLE |=> $stable(boot_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("boot mode changed"); // R22

    property p_dmac_reset;
        disable iff (1'b0) reset |=> port_dma_control_q == PORT_DMA_CONTROL_RST
                                     && count_q == BOOT_COUNT_RST && index_q == BOOT_INDEX_RST;
    endproperty
    a_dmac_reset: assert property (p_dmac_reset) else $error("dma reset values wrong"); // R3

    property p_grant_needs_request;
        host_bus_grant |-> $past(host_s2[2], 1) && boot_mode == MODE_HOST;
    endproperty
    a_grant_needs_request: assert property (p_grant_needs_request) // R2
        else $error("grant without request");

    property p_idle_pc;
        state_q == ST_WAIT |-> pc == PC_IDLE && !port_wakeup_interrupt;
    endproperty
    a_idle_pc: assert property (p_idle_pc) else $error("pc not idle during boot"); // R7

    property p_load_range;
        mem_we |-> mem_addr >= BOOT_INDEX_RST && mem_addr <= BOOT_LAST_ADDR
                   && index_q == mem_addr + 32'h1;
    endproperty
    a_load_range: assert property (p_load_range) else $error("load outside boot area"); // R5

    property p_wake;
        state_q == ST_WAIT && mem_we && count_q == 16'h0 |=>
            port_wakeup_interrupt && pc == PC_WAKE_VECTOR && state_q == ST_RUN
            ##1 !port_wakeup_interrupt;
    endproperty
    a_wake: assert property (p_wake) else $error("wake sequence wrong"); // R11

    property p_rti;
        rti && state_q == ST_RUN && pc == PC_WAKE_VECTOR |=> pc == PC_RESET_ROUTINE;
    endproperty
    a_rti: assert property (p_rti) else $error("rti did not resume"); // R13

    property p_ack_high;
        disable iff (1'b0) reset |=> ack_o && ack_oe;
    endproperty
    a_ack_high: assert property (p_ack_high) else $error("ack not kept high"); // R12

    property p_link_override;
        wb_req && !wb_we_i && wb_hit(wb_adr_i, REG_LINK_CONTROL) && boot_mode == MODE_LINK
            && state_q == ST_WAIT |=> wb_dat_o[LINK_WIDTH48_BIT];
    endproperty
    a_link_override: assert property (p_link_override) else $error("no 48-bit override"); // R20

    c_host_done: cover property (boot_mode == MODE_HOST && port_wakeup_interrupt);
    c_link_done: cover property (boot_mode == MODE_LINK && port_wakeup_interrupt);
    c_rti:       cover property (pc == PC_WAKE_VECTOR ##[1:50] pc == PC_RESET_ROUTINE);
endmodule : hlb_boot_loader

// ---- verification/hlb_far_side.sv ----
// far side model: host processor writes and link nibble source
`timescale 1ns/1ps
module hlb_far_side
    import hlb_pkg::*;
(
    input  wire logic   clk,
    output logic        host_bus_request,
    output logic        host_chip_select,
    output logic        host_write,
    output logic        host_addr,
    output logic [15:0] host_data,
    output logic        link_clock,
    output logic [3:0]  link_data
);
    initial begin
        host_bus_request = 1'b0;
        host_chip_select = 1'b0;
        host_write       = 1'b0;
        host_addr        = 1'b0;
        host_data        = 16'h0000;
        link_clock       = 1'b1;
        link_data        = 4'h0;
    end

    task automatic arbitrate(input logic on);
        @(posedge clk);
        host_bus_request <= on;
        host_chip_select <= on;
    endtask : arbitrate

    // data settles 4 cycles ahead of the strobe and outlives it by 4
    task automatic host_wr(input logic a, input logic [15:0] d);
        @(posedge clk);
        host_addr <= a;
        host_data <= d;
        repeat (4) @(posedge clk);
        host_write <= 1'b1;
        repeat (4) @(posedge clk);
        host_write <= 1'b0;
        repeat (4) @(posedge clk);
        host_data <= ~d;
    endtask : host_wr

    // 80 ns strobe, slower than the core clock; idles high between words
    task automatic link_word(input logic [47:0] w);
        @(posedge clk);
        for (int i = 11; i >= 0; i--) begin
            link_data <= w[i*4+:4];
            repeat (5) @(posedge clk);
            link_clock <= 1'b0;
            repeat (5) @(posedge clk);
            link_clock <= 1'b1;
        end
        link_data <= ~w[3:0];
    endtask : link_word
endmodule : hlb_far_side

// ---- verification/hlb_boot_loader_bench.sv ----
// self-checking bench for the host and link boot loader
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin n_errors++; \
    $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module hlb_boot_loader_bench
    import hlb_pkg::*;
();
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'hf;
    logic        wb_we_i = 1'b0;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        external_boot_select = 1'b0;
    logic        link_boot_select = 1'b0;
    logic        boot_memory_select = 1'b1;
    logic        rti = 1'b0;
    logic        host_bus_request, host_chip_select, host_write, host_addr;
    logic [15:0] host_data;
    logic        link_clock;
    logic [3:0]  link_data;
    logic [31:0] wb_dat_o, mem_addr, pc;
    logic        wb_ack_o, host_bus_grant, host_ready, ack_o, ack_oe, mem_we;
    logic [47:0] mem_wdata;
    logic        port_wakeup_interrupt;
    logic [1:0]  boot_mode;
    int          n_errors = 0;
    int          tests_run = 0;
    int          n_words = 0;
    int          n_wake = 0;

    initial forever #4 clk = ~clk;

    hlb_far_side far (.clk, .host_bus_request, .host_chip_select, .host_write,
        .host_addr, .host_data, .link_clock, .link_data);

    hlb_boot_loader dut (.clk, .reset, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_we_i,
        .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .external_boot_select,
        .link_boot_select, .boot_memory_select, .host_bus_request, .host_chip_select,
        .host_write, .host_addr, .host_data, .host_bus_grant, .host_ready, .ack_o,
        .ack_oe, .link_clock, .link_data, .rti, .mem_we, .mem_addr, .mem_wdata,
        .port_wakeup_interrupt, .pc, .boot_mode);

    function automatic logic [47:0] exp_word(input int n);
        return {16'h9e37 ^ 16'(n), 16'h1234 + 16'(n), ~16'(n)};
    endfunction : exp_word

    always @(posedge clk) begin
        if (reset) begin
            n_words = 0;
            n_wake = 0;
        end else if (mem_we === 1'b1) begin
            `CHK("mem_addr", BOOT_INDEX_RST + n_words, mem_addr)
            `CHK("mem_wdata", exp_word(n_words), mem_wdata)
            `CHK("pc_loading", PC_IDLE, pc)
            n_words = n_words + 1;
        end
        // the pulse may come while a host write task is still running
        if (port_wakeup_interrupt === 1'b1) begin
            `CHK("wake_at_end", 256, n_words)
            n_wake = n_wake + 1;
        end
    end

    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        int t;
        @(posedge clk);
        wb_adr_i <= a;
        wb_we_i  <= w;
        wb_dat_i <= d;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        t = 0;
        do begin
            @(posedge clk);
            t++;
        end while (wb_ack_o !== 1'b1 && t < 20);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        `CHK("wb_ack", 1'b1, wb_ack_o)
    endtask : wb

    task automatic do_reset(input logic e, input logic l, input logic b);
        logic [31:0] q;
        @(posedge clk);
        reset <= 1'b1;
        external_boot_select <= e;
        link_boot_select <= l;
        boot_memory_select <= b;
        repeat (5) @(posedge clk);
        `CHK("ack_o_rst", 1'b1, ack_o)
        `CHK("ack_oe_rst", 1'b1, ack_oe)
        reset <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("pc_idle", PC_IDLE, pc)
        wb(REG_PORT_INTERNAL_INDEX, 1'b0, 32'h0, q);
        `CHK("index_rst", BOOT_INDEX_RST, q)
        wb(REG_PORT_INTERNAL_COUNT, 1'b0, 32'h0, q);
        `CHK("count_rst", BOOT_COUNT_RST, q[15:0])
    endtask : do_reset

    task automatic finish_boot();
        logic [31:0] q;
        int          t;
        t = 0;
        while (n_wake == 0 && t < 100) begin
            @(posedge clk);
            t++;
        end
        `CHK("wake_pulse", 1, n_wake)
        `CHK("pc_vector", PC_WAKE_VECTOR, pc)
        `CHK("word_total", 256, n_words)
        wb(REG_PORT_INTERNAL_COUNT, 1'b0, 32'h0, q);
        `CHK("count_zero", 16'h0000, q[15:0])
        rti <= 1'b1;
        @(posedge clk);
        rti <= 1'b0;
        `CHK("wake_once", 1'b0, port_wakeup_interrupt)
        @(posedge clk);
        `CHK("pc_resume", PC_RESET_ROUTINE, pc)
    endtask : finish_boot

    task automatic host_run(input logic wide, input int nw);
        logic [31:0] q;
        logic [47:0] w;
        int          t;
        do_reset(1'b0, 1'b0, 1'b1);
        `CHK("mode_host", MODE_HOST, boot_mode)
        wb(REG_PORT_DMA_CONTROL, 1'b0, 32'h0, q);
        `CHK("dma_ctl_rst", PORT_DMA_CONTROL_RST, q)
        `CHK("lsb_first", 1'b0, q[WORD_ORDER_FLAG])
        wb(8'h3c, 1'b0, 32'h0, q);
        `CHK("unmapped", 32'h0, q)
        `CHK("no_grant", 1'b0, host_bus_grant)
        far.arbitrate(1'b1);
        t = 0;
        while (!(host_bus_grant === 1'b1 && host_ready === 1'b1) && t < 50) begin
            @(posedge clk);
            t++;
        end
        `CHK("grant_ready", 1'b1, host_bus_grant & host_ready)
        if (wide) begin
            far.host_wr(1'b1, 16'h0001);
            wb(REG_SYSTEM_CONFIGURATION, 1'b0, 32'h0, q);
            `CHK("width16", 1'b1, q[SYSTEM_CONFIGURATION_WIDTH16_BIT])
        end
        for (int n = 0; n < nw; n++) begin
            w = exp_word(n);
            for (int p = 0; p < (wide ? 3 : 6); p++) begin
                far.host_wr(1'b0, wide ? w[p*16+:16] : {8'h00, w[p*8+:8]});
            end
            if (n == 0) begin
                wb(REG_PORT_INTERNAL_COUNT, 1'b0, 32'h0, q);
                `CHK("count_dec", 16'h00ff, q[15:0])
            end
        end
        far.arbitrate(1'b0);
    endtask : host_run

    task automatic link_run();
        logic [31:0] q;
        do_reset(1'b0, 1'b1, 1'b1);
        `CHK("mode_link", MODE_LINK, boot_mode)
        // pins move after release; the latched mode must not follow
        link_boot_select <= 1'b0;
        wb(REG_LINK_CONTROL, 1'b0, 32'h0, q);
        `CHK("link48", 1'b1, q[LINK_WIDTH48_BIT])
        for (int n = 0; n < 256; n++) begin
            far.link_word(exp_word(n));
        end
        finish_boot();
        `CHK("mode_held", MODE_LINK, boot_mode)
    endtask : link_run

    task automatic summarize();
        $display("tests_run=%0d n_errors=%0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : summarize

    // the two full loads take about 41000 cycles
    initial begin
        repeat (80000) @(posedge clk);
        n_errors++;
        summarize();
    end

    initial begin
        host_run(1'b0, 1);
        host_run(1'b1, 256);
        finish_boot();
        link_run();
        // unsupported pin code: no mode, no grant, loader parked
        do_reset(1'b0, 1'b1, 1'b0);
        `CHK("mode_other", MODE_NONE, boot_mode)
        `CHK("other_no_grant", 1'b0, host_bus_grant)
        summarize();
    end
endmodule : hlb_boot_loader_bench
